/* ptl_pkg.sv */
// package for the phase threshold and load current readout block
package ptl_pkg;

    // register offsets on the serial register port
    localparam logic [7:0] PTL_ADDR_PHASE_LEVELS = 8'h1f;
    localparam logic [7:0] PTL_ADDR_SRC_SELECT = 8'h21;
    localparam logic [7:0] PTL_ADDR_CURR_LSB = 8'h22;
    localparam logic [7:0] PTL_ADDR_READY_FLAG = 8'h2d;
    localparam logic [7:0] PTL_ADDR_IRQ_MASK = 8'h2e;

    // field positions
    localparam int PTL_ADD_LSB = 4;
    localparam int PTL_DROP_LSB = 0;
    localparam int PTL_SRC_LSB = 0;
    localparam int PTL_CURR_MSB_LSB = 4;
    localparam int PTL_READY_BIT = 0;
    localparam int PTL_MASK_BIT = 3;

    // values after reset
    localparam logic [7:0] PTL_RST_PHASE_LEVELS = 8'h42;
    localparam logic [7:0] PTL_RST_SRC_SELECT = 8'h00;
    localparam logic [10:0] PTL_RST_CURRENT = 11'h000;
    localparam logic [7:0] PTL_RST_IRQ_MASK = 8'h08;
    localparam logic [2:0] PTL_RST_PHASES = 3'h1;

    // selector codes and phase limits
    localparam logic [2:0] PTL_SRC_TOTAL = 3'h6;
    localparam logic [2:0] PTL_SRC_RSVD = 3'h7;
    localparam int PTL_NUM_CORES = 6;
    localparam logic [2:0] PTL_MAX_PHASES = 3'h6;
    localparam logic [2:0] PTL_MIN_PHASES = 3'h1;
    localparam logic [2:0] PTL_ADD_MIN_CODE = 3'h2;
    localparam logic [2:0] PTL_DROP_MAX_CODE = 3'h5;

    // current coding: 10 mA per count, saturating code
    localparam int PTL_MA_PER_LSB = 10;
    localparam logic [10:0] PTL_CURR_SAT = 11'h7ff;
    // threshold = (code + offset) * 100 mA, in counts of 10 mA
    localparam logic [9:0] PTL_THR_OFFSET = 10'h003;
    localparam logic [9:0] PTL_THR_STEP = 10'h00a;

    // averaging window timing
    localparam int PTL_CLK_MHZ = 100;
    localparam int PTL_WINDOW_MS = 5;
    localparam int PTL_WINDOW_CYC_DEF = PTL_WINDOW_MS * 1000 * PTL_CLK_MHZ;
    localparam int PTL_SAMPLES_LOG2 = 6;
    localparam logic [5:0] PTL_LAST_SAMPLE = 6'h3f;

    // per-core current inputs, 10 mA per count
    typedef struct packed {
        logic [PTL_NUM_CORES-1:0][10:0] core;
    } ptl_core_curr_t;

    // register port request
    typedef struct packed {
        logic wr_en;
        logic rd_en;
        logic [7:0] addr;
        logic [7:0] wr_data;
    } ptl_reg_req_t;

    // whole state of the block
    typedef struct packed {
        logic [7:0] phase_levels_reg;
        logic [7:0] src_ctrl;
        logic [10:0] measured_load_current;
        logic ready_flag;
        logic current_ready_irq_mask;
        logic irq;
        logic [2:0] active_phases;
        logic [19:0] tick_cnt;
        logic [5:0] sample_cnt;
        logic [16:0] acc;
        logic [7:0] rd_data;
    } ptl_state_t;

endpackage : ptl_pkg

/* ptl_readout.sv */
// phase threshold registers, load current averaging and phase control
`timescale 1ns/1ps

// Functional notes
// - add level code in bits 6:4, reset 100, 0.5-1.0 A per phase.
// - drop level code in bits 2:0, reset 010, 0.3-0.8 A per phase.
// - source select 0-5 picks a core, 6 the total, 7 reserved.
// - 11-bit result, top three bits in select reg 6:4, low byte separate.
// - 10 mA per count, zero below 10 mA, all ones saturates.
// - result is average of selected source over last 5 ms.
// - result bytes reset to zero on every reset.
// - new result sets ready flag; interrupt only when mask is 0, mask resets 1.
module ptl_readout #(
    parameter int WINDOW_CYC = ptl_pkg::PTL_WINDOW_CYC_DEF
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire ptl_pkg::ptl_reg_req_t reg_req,
    output logic [7:0] reg_rd_data,
    input wire ptl_pkg::ptl_core_curr_t core_curr,
    output logic [2:0] active_phases,
    output logic load_ready_irq
);
    import ptl_pkg::*;

    localparam int SAMPLE_CYC = WINDOW_CYC >> PTL_SAMPLES_LOG2;
    localparam logic [19:0] TICK_LAST = 20'(SAMPLE_CYC - 1);

    ptl_state_t state_ff;
    ptl_state_t nxt_state;

    ////////////////////////////////////////////////////////////////////////////
    // threshold code to counts of 10 mA for one phase
    function automatic logic [9:0] thr_counts(input logic [2:0] code);
        thr_counts = 10'((10'(code) + PTL_THR_OFFSET) * PTL_THR_STEP);
    endfunction : thr_counts

    ////////////////////////////////////////////////////////////////////////////
    // total and selected source currents
    logic [13:0] total_sum;
    logic [10:0] total_sat;
    logic [10:0] sel_curr;
    logic [2:0] src_sel;
    logic [2:0] add_code;
    logic [2:0] drop_code;
    logic [12:0] add_thr;
    logic [12:0] drop_thr;
    logic tick;

    // sum of all cores, clipped to the top code
    always_comb begin
        total_sum = '0;
        for (int i = 0; i < PTL_NUM_CORES; i++) begin
            total_sum = total_sum + 14'(core_curr.core[i]);
        end
        total_sat = (total_sum > 14'(PTL_CURR_SAT)) ? PTL_CURR_SAT : total_sum[10:0];
    end

    // source mux
    always_comb begin
        src_sel = state_ff.src_ctrl[PTL_SRC_LSB +: 3];
        if (src_sel == PTL_SRC_TOTAL) begin
            sel_curr = total_sat;
        end else if (src_sel == PTL_SRC_RSVD) begin
            sel_curr = '0;
        end else begin
            sel_curr = core_curr.core[src_sel];
        end
    end

    // scaled thresholds; reserved codes clamp to the nearest legal one
    always_comb begin
        add_code = state_ff.phase_levels_reg[PTL_ADD_LSB +: 3];
        drop_code = state_ff.phase_levels_reg[PTL_DROP_LSB +: 3];
        if (add_code < PTL_ADD_MIN_CODE) begin
            add_code = PTL_ADD_MIN_CODE;
        end
        if (drop_code > PTL_DROP_MAX_CODE) begin
            drop_code = PTL_DROP_MAX_CODE;
        end
        add_thr = 13'(thr_counts(add_code) * state_ff.active_phases);
        drop_thr = 13'(thr_counts(drop_code) * state_ff.active_phases);
    end

    assign tick = (state_ff.tick_cnt == TICK_LAST);

    ////////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        logic wr;
        logic [16:0] acc_sum;
        wr = reg_req.wr_en;
        acc_sum = state_ff.acc + 17'(sel_curr);
        nxt_state = state_ff;

        // register writes; result bits are never written
        if (wr && reg_req.addr == PTL_ADDR_PHASE_LEVELS) begin
            nxt_state.phase_levels_reg = reg_req.wr_data;
        end
        if (wr && reg_req.addr == PTL_ADDR_IRQ_MASK) begin
            nxt_state.current_ready_irq_mask = reg_req.wr_data[PTL_MASK_BIT];
        end
        if (wr && reg_req.addr == PTL_ADDR_SRC_SELECT) begin
            nxt_state.src_ctrl = reg_req.wr_data & 8'h8f;
        end

        // sampling ticks across the window
        nxt_state.tick_cnt = tick ? 20'h00000 : state_ff.tick_cnt + 20'h00001;
        if (wr && reg_req.addr == PTL_ADDR_SRC_SELECT) begin
            // new source: restart the window so no stale samples mix in
            nxt_state.tick_cnt = '0;
            nxt_state.sample_cnt = '0;
            nxt_state.acc = '0;
        end else if (tick) begin
            nxt_state.sample_cnt = state_ff.sample_cnt + 6'h01;
            nxt_state.acc = acc_sum;
            if (state_ff.sample_cnt == PTL_LAST_SAMPLE) begin
                nxt_state.measured_load_current = 11'(acc_sum >> PTL_SAMPLES_LOG2);
                nxt_state.acc = '0;
            end
        end

        // ready flag: write one clears, a new result in the same cycle wins
        if (wr && reg_req.addr == PTL_ADDR_READY_FLAG && reg_req.wr_data[PTL_READY_BIT]) begin
            nxt_state.ready_flag = 1'b0;
        end
        if (tick && state_ff.sample_cnt == PTL_LAST_SAMPLE
            && !(wr && reg_req.addr == PTL_ADDR_SRC_SELECT)) begin
            nxt_state.ready_flag = 1'b1;
        end
        nxt_state.irq = nxt_state.ready_flag && !nxt_state.current_ready_irq_mask;

        // phase add and drop, one step per sample tick
        if (tick) begin
            if (13'(total_sat) > add_thr && state_ff.active_phases < PTL_MAX_PHASES) begin
                nxt_state.active_phases = state_ff.active_phases + 3'h1;
            end else if (13'(total_sat) < drop_thr && state_ff.active_phases > PTL_MIN_PHASES) begin
                nxt_state.active_phases = state_ff.active_phases - 3'h1;
            end
        end

        // registered read data, unmapped addresses read zero
        nxt_state.rd_data = '0;
        if (reg_req.rd_en) begin
            unique case (reg_req.addr)
                PTL_ADDR_PHASE_LEVELS: nxt_state.rd_data = state_ff.phase_levels_reg;
                PTL_ADDR_SRC_SELECT: begin
                    nxt_state.rd_data = state_ff.src_ctrl;
                    nxt_state.rd_data[PTL_CURR_MSB_LSB +: 3] = state_ff.measured_load_current[10:8];
                end
                PTL_ADDR_CURR_LSB: nxt_state.rd_data = state_ff.measured_load_current[7:0];
                PTL_ADDR_READY_FLAG: nxt_state.rd_data = {7'h00, state_ff.ready_flag};
                PTL_ADDR_IRQ_MASK: nxt_state.rd_data = {4'h0, state_ff.current_ready_irq_mask, 3'h0};
                default: nxt_state.rd_data = '0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_ff <= '0;
            state_ff.phase_levels_reg <= PTL_RST_PHASE_LEVELS;
            state_ff.src_ctrl <= PTL_RST_SRC_SELECT;
            state_ff.measured_load_current <= PTL_RST_CURRENT;
            state_ff.current_ready_irq_mask <= PTL_RST_IRQ_MASK[PTL_MASK_BIT];
            state_ff.active_phases <= PTL_RST_PHASES;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign reg_rd_data = state_ff.rd_data;
    assign active_phases = state_ff.active_phases;
    assign load_ready_irq = state_ff.irq;

    ////////////////////////////////////////////////////////////////////////////
    // assertions
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    a_result_ro_write: assert property ((reg_req.wr_en && !tick) |=>
        $stable(state_ff.measured_load_current)) else $error("result changed without window end");
    a_sel_writable: assert property ((reg_req.wr_en && reg_req.addr == PTL_ADDR_SRC_SELECT) |=>
        state_ff.src_ctrl[2:0] == $past(reg_req.wr_data[2:0])) else $error("selector not written");
    a_add_write: assert property ((reg_req.wr_en && reg_req.addr == PTL_ADDR_PHASE_LEVELS) |=>
        state_ff.phase_levels_reg == $past(reg_req.wr_data)) else $error("level register not written");
    a_msb_readback: assert property ((reg_req.rd_en && reg_req.addr == PTL_ADDR_SRC_SELECT) |=>
        reg_rd_data[6:4] == $past(state_ff.measured_load_current[10:8])) else $error("msb readback wrong");
    a_lsb_readback: assert property ((reg_req.rd_en && reg_req.addr == PTL_ADDR_CURR_LSB) |=>
        reg_rd_data == $past(state_ff.measured_load_current[7:0])) else $error("lsb readback wrong");
    a_ready_irq_mask: assert property (state_ff.current_ready_irq_mask |-> !load_ready_irq)
        else $error("masked ready raised interrupt");
    a_ready_set: assert property ((tick && state_ff.sample_cnt == PTL_LAST_SAMPLE
        && !(reg_req.wr_en && reg_req.addr == PTL_ADDR_SRC_SELECT)) |=> state_ff.ready_flag
        ##0 (load_ready_irq == !state_ff.current_ready_irq_mask)) else $error("ready flag not set");
    a_phase_add: assert property ((tick && 13'(total_sat) > add_thr
        && state_ff.active_phases < PTL_MAX_PHASES) |=> active_phases == $past(active_phases) + 3'h1)
        else $error("phase not added");
    a_phase_drop: assert property ((tick && 13'(total_sat) < drop_thr && 13'(total_sat) <= add_thr
        && state_ff.active_phases > PTL_MIN_PHASES) |=> active_phases == $past(active_phases) - 3'h1)
        else $error("phase not dropped");
    a_phase_range: assert property (active_phases >= PTL_MIN_PHASES && active_phases <= PTL_MAX_PHASES)
        else $error("phase count out of range");
    a_total_sat: assert property ((total_sum > 14'(PTL_CURR_SAT)) |-> total_sat == PTL_CURR_SAT)
        else $error("total not saturated");

    c_result_ready: cover property (!state_ff.ready_flag ##1 state_ff.ready_flag);
    c_irq_seen: cover property (load_ready_irq);
    c_phase_up: cover property (active_phases == 3'h1 ##1 active_phases == 3'h2);
    c_total_source: cover property (state_ff.src_ctrl[2:0] == PTL_SRC_TOTAL && state_ff.ready_flag);

endmodule : ptl_readout

/* ptl_readout_tb.sv */
// testbench for the phase threshold and load current readout block
`timescale 1ns/1ps

module tb;
    import ptl_pkg::*;

    localparam int WIN = 640;
    logic clk_sys;
    logic rst;
    ptl_reg_req_t reg_req;
    logic [7:0] reg_rd_data;
    ptl_core_curr_t core_curr;
    logic [2:0] active_phases;
    logic load_ready_irq;
    int errors;
    int total_checks;
    logic [10:0] exp_cur;

    ptl_readout #(.WINDOW_CYC(WIN)) dut (
        .clk_sys(clk_sys),
        .rst(rst),
        .reg_req(reg_req),
        .reg_rd_data(reg_rd_data),
        .core_curr(core_curr),
        .active_phases(active_phases),
        .load_ready_irq(load_ready_irq)
    );

    ////////////////////////////////////////////////////////////////////////
    // clock and watchdog
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    initial begin
        repeat (20000) @(posedge clk_sys);
        errors = errors + 1;
        wrap_up();
    end

    ////////////////////////////////////////////////////////////////////////
    // register port tasks and compares
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk_sys);
        reg_req <= '{wr_en: 1'b1, rd_en: 1'b0, addr: a, wr_data: v};
        @(posedge clk_sys);
        reg_req <= '0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk_sys);
        reg_req <= '{wr_en: 1'b0, rd_en: 1'b1, addr: a, wr_data: 8'h00};
        @(posedge clk_sys);
        reg_req <= '0;
        #1 v = reg_rd_data;
    endtask : rd

    task automatic cmp_reg(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] g;
        rd(a, g);
        total_checks = total_checks + 1;
        if (g !== e) begin
            errors = errors + 1;
            $display("BAD %0t reg %h read %h expected %h", $time, a, g, e);
        end
    endtask : cmp_reg

    task automatic cmp_bit(input logic g, input logic e);
        total_checks = total_checks + 1;
        if (g !== e) begin
            errors = errors + 1;
            $display("BAD %0t interrupt %b expected %b", $time, g, e);
        end
    endtask : cmp_bit

    task automatic cmp_ph(input logic [2:0] e);
        total_checks = total_checks + 1;
        if (active_phases !== e) begin
            errors = errors + 1;
            $display("BAD %0t phases %0d expected %0d", $time, active_phases, e);
        end
    endtask : cmp_ph

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : cyc

    task automatic wrap_up();
        if (errors == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : wrap_up

    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        errors = 0;
        total_checks = 0;
        rst <= 1'b1;
        reg_req <= '0;
        for (int i = 0; i < 6; i++) begin
            core_curr.core[i] <= 11'h190 + 11'(i);
        end
        cyc(2);
        rst <= 1'b0;
        // defaults after reset
        cmp_ph(3'h1);
        cmp_reg(8'h1f, 8'h42);
        cmp_reg(8'h21, 8'h00);
        cmp_reg(8'h22, 8'h00);
        cmp_reg(8'h2e, 8'h08);
        cmp_reg(8'h2d, 8'h00);
        cmp_reg(8'h30, 8'h00);
        // every source code, total saturates at the all-ones code
        for (int s = 0; s < 8; s++) begin
            exp_cur = (s < 6) ? 11'h190 + 11'(s) : ((s == 6) ? 11'h7ff : 11'h000);
            wr(8'h21, 8'(s));
            cyc(700);
            cmp_reg(8'h21, {1'b0, exp_cur[10:8], 1'b0, 3'(s)});
            cmp_reg(8'h22, exp_cur[7:0]);
        end
        wr(8'h21, 8'h06);
        cyc(700);
        cmp_ph(3'h6);
        cmp_bit(load_ready_irq, 1'b0);
        cmp_reg(8'h2d, 8'h01);
        // result fields ignore writes, other bits stay writable
        wr(8'h21, 8'h8e);
        cmp_reg(8'h21, 8'hfe);
        wr(8'h22, 8'h55);
        cmp_reg(8'h22, 8'hff);
        // unmask, clear, wait for next result, mask again
        wr(8'h2e, 8'h00);
        cyc(2);
        cmp_bit(load_ready_irq, 1'b1);
        wr(8'h2d, 8'h01);
        cyc(2);
        cmp_bit(load_ready_irq, 1'b0);
        cyc(700);
        cmp_bit(load_ready_irq, 1'b1);
        wr(8'h2e, 8'h08);
        cyc(2);
        cmp_bit(load_ready_irq, 1'b0);
        // idle load sheds down to one phase
        for (int i = 0; i < 6; i++) begin
            core_curr.core[i] <= 11'h000;
        end
        cyc(100);
        cmp_ph(3'h1);
        // add 0.7 A per phase, drop 0.3 A per phase, edges of both levels
        wr(8'h1f, 8'h40);
        cmp_reg(8'h1f, 8'h40);
        core_curr.core[0] <= 11'd70;
        cyc(50);
        cmp_ph(3'h1);
        core_curr.core[0] <= 11'd71;
        cyc(30);
        cmp_ph(3'h2);
        core_curr.core[0] <= 11'd60;
        cyc(50);
        cmp_ph(3'h2);
        core_curr.core[0] <= 11'd59;
        cyc(30);
        cmp_ph(3'h1);
        // reserved add code acts as 0.5 A: 0.45 A must not add a phase
        core_curr.core[0] <= 11'd45;
        wr(8'h1f, 8'h10);
        cyc(50);
        cmp_ph(3'h1);
        cyc(10);
        cmp_ph(3'h1);
        // reserved drop code acts as 0.8 A: 1.7 A on two phases must hold
        wr(8'h1f, 8'h76);
        core_curr.core[0] <= 11'd170;
        cyc(50);
        cmp_ph(3'h2);
        cyc(10);
        cmp_ph(3'h2);
        // half window at 1.0 A, half at 3.0 A averages to 2.0 A
        core_curr.core[0] <= 11'd100;
        wr(8'h21, 8'h00);
        cyc(320);
        core_curr.core[0] <= 11'd300;
        cyc(380);
        cmp_reg(8'h22, 8'hc8);
        cmp_reg(8'h21, 8'h00);
        // reset in mid-run clears result and restores default levels
        rst <= 1'b1;
        cyc(2);
        rst <= 1'b0;
        cmp_ph(3'h1);
        cmp_reg(8'h22, 8'h00);
        cmp_reg(8'h1f, 8'h42);
        wrap_up();
    end
endmodule : tb
